// >>> hdl/swdb_params.svh
`ifndef SWDB_PARAMS_SVH
`define SWDB_PARAMS_SVH

// link timing, times in picoseconds
`define SWDB_CLK_PS 8000
`define SWDB_BIT_PS 41667
`define SWDB_BIT_CYC ((`SWDB_BIT_PS) / (`SWDB_CLK_PS))
`define SWDB_HALF_CYC ((`SWDB_BIT_CYC) / 2)
// pin synchroniser latency and the round trip through two of them
`define SWDB_SYNC_LAT 3
`define SWDB_LINK_LAT (2 * ((`SWDB_SYNC_LAT) + 1))
// device sample points and end of receive, counted from the first cycle of the mark
`define SWDB_SLOT0 ((`SWDB_LINK_LAT) + (`SWDB_BIT_CYC) + (`SWDB_HALF_CYC))
`define SWDB_SLOT1 ((`SWDB_SLOT0) + (`SWDB_BIT_CYC))
`define SWDB_SLOT2 ((`SWDB_SLOT0) + 2 * (`SWDB_BIT_CYC))
`define SWDB_SLOT3 ((`SWDB_SLOT0) + 3 * (`SWDB_BIT_CYC))
// adapter quiet time before it reports the transaction done
`define SWDB_GAP_CYC (2 * (`SWDB_BIT_CYC))

`endif

// >>> hdl/swdb_pkg.sv
package swdb_pkg;
	typedef logic [5:0] swdb_cnt_t;

	typedef enum logic [2:0] {
		D_IDLE = 3'b000,
		D_MARK = 3'b001,
		D_RECV = 3'b010,
		D_WAIT = 3'b011,
		D_ACK = 3'b100,
		D_TDO = 3'b101,
		D_DONE = 3'b110
	} swdb_dev_state_e;

	typedef enum logic [2:0] {
		A_IDLE = 3'b000,
		A_START = 3'b001,
		A_MARK = 3'b010,
		A_SEND = 3'b011,
		A_WAIT = 3'b100,
		A_TDO = 3'b101,
		A_DONE = 3'b110
	} swdb_ada_state_e;
endpackage

// >>> hdl/swdb_if.sv
interface swdb_if;
	logic dev_o;
	logic dev_oe;
	logic ada_o;
	logic ada_oe;
	logic line;

	// wire level: any low drive wins, an undriven wire is pulled low
	assign line = (dev_oe | ada_oe) & ~(dev_oe & ~dev_o) & ~(ada_oe & ~ada_o);

	modport device (input line, output dev_o, output dev_oe);
	modport adapter (input line, output ada_o, output ada_oe);
endinterface

// >>> hdl/swdb_sync.sv
module swdb_sync (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// asynchronous level in, filtered level out
	input wire logic d,
	output logic q
);
	logic s1_r;
	logic s2_r;
	logic s3_r;
	logic hold_r;
	logic agree;

	// a change counts once the second and third stages agree
	assign agree = s2_r == s3_r;
	assign q = agree ? s3_r : hold_r;

	// three stage shift, first stage feeds only the second
	always_ff @(posedge clk) begin
		if (reset) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			hold_r <= 1'b0;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
			hold_r <= q;
		end
	end
endmodule // swdb_sync

// >>> hdl/swdb_device.sv
`include "swdb_params.svh"

module swdb_device import swdb_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// one-wire link
	swdb_if.device link,
	// processor tap
	output logic tap_tck,
	output logic tap_tdi,
	output logic tap_tms,
	output logic tap_trst_n,
	input wire logic tap_rtck,
	input wire logic tap_tdo,
	// status
	output logic busy
);
	swdb_dev_state_e state_r, state_nxt;
	swdb_cnt_t cnt_r, cnt_nxt;
	logic oe_r, oe_nxt;
	logic o_r, o_nxt;
	logic marker_r, marker_nxt;
	logic tdi_r, tdi_nxt;
	logic tms_r, tms_nxt;
	logic tck_r, tck_nxt;
	logic ttdi_r, ttdi_nxt;
	logic ttms_r, ttms_nxt;
	logic trst_n_r, trst_n_nxt;
	logic tdo_bit_r, tdo_bit_nxt;
	logic line_s;
	logic rtck_s;
	logic tdo_s;

	// wire, return clock and tdo all come from outside this clock
	swdb_sync u_line (
		.clk(clk),
		.reset(reset),
		.d(link.line),
		.q(line_s)
	);
	swdb_sync u_rtck (
		.clk(clk),
		.reset(reset),
		.d(tap_rtck),
		.q(rtck_s)
	);
	swdb_sync u_tdo (
		.clk(clk),
		.reset(reset),
		.d(tap_tdo),
		.q(tdo_s)
	);

	// counter decodes
	wire bit_end = cnt_r == swdb_cnt_t'(`SWDB_BIT_CYC - 1);
	wire at_marker = cnt_r == swdb_cnt_t'(`SWDB_SLOT0);
	wire at_tdi = cnt_r == swdb_cnt_t'(`SWDB_SLOT1);
	wire at_tms = cnt_r == swdb_cnt_t'(`SWDB_SLOT2);
	wire at_end = cnt_r == swdb_cnt_t'(`SWDB_SLOT3);
	wire swdb_cnt_t cnt_inc = swdb_cnt_t'(cnt_r + swdb_cnt_t'(1)); // full counter width

	// transaction sequencer
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_inc;
		oe_nxt = oe_r;
		o_nxt = o_r;
		marker_nxt = marker_r;
		tdi_nxt = tdi_r;
		tms_nxt = tms_r;
		tck_nxt = tck_r;
		ttdi_nxt = ttdi_r;
		ttms_nxt = ttms_r;
		trst_n_nxt = trst_n_r;
		tdo_bit_nxt = tdo_bit_r;
		case (state_r)
			D_IDLE: begin
				cnt_nxt = '0;
				if (line_s) begin
					// start edge seen: mark by driving low
					state_nxt = D_MARK;
					oe_nxt = 1'b1;
					o_nxt = 1'b0;
				end
			end
			D_MARK: begin
				if (bit_end) begin
					// low held one bit period, then let go
					oe_nxt = 1'b0;
					state_nxt = D_RECV;
				end
			end
			D_RECV: begin
				// sample mid-slot, using the mark as time zero
				if (at_marker) begin
					marker_nxt = line_s;
				end
				if (at_tdi) begin
					tdi_nxt = line_s;
				end
				if (at_tms) begin
					tms_nxt = line_s;
				end
				if (at_end) begin
					cnt_nxt = '0;
					if (marker_r) begin
						// clock cycle: raise tck with the bits
						tck_nxt = 1'b1;
						ttdi_nxt = tdi_r;
						ttms_nxt = tms_r;
						state_nxt = D_WAIT;
					end else begin
						// low marker, or a glitch start, resets the tap
						trst_n_nxt = 1'b0;
						state_nxt = D_DONE;
					end
				end
			end
			D_WAIT: begin
				// no timeout: the tap answers when it answers
				cnt_nxt = '0;
				if (rtck_s) begin
					tck_nxt = 1'b0;
					tdo_bit_nxt = tdo_s;
					oe_nxt = 1'b1;
					o_nxt = 1'b1;
					state_nxt = D_ACK;
				end
			end
			D_ACK: begin
				if (bit_end) begin
					// tdo starts on the edge after the high pulse
					o_nxt = tdo_bit_r;
					cnt_nxt = '0;
					state_nxt = D_TDO;
				end
			end
			D_TDO: begin
				if (bit_end) begin
					oe_nxt = 1'b0;
					o_nxt = 1'b0;
					cnt_nxt = '0;
					state_nxt = D_DONE;
				end
			end
			D_DONE: begin
				// guard so the fading drive is not taken as a new start
				if (bit_end) begin
					trst_n_nxt = 1'b1;
				end
				if (!bit_end && cnt_r > swdb_cnt_t'(`SWDB_BIT_CYC - 1)) begin
					cnt_nxt = cnt_r;
				end
				if (cnt_r >= swdb_cnt_t'(`SWDB_BIT_CYC - 1) && !line_s) begin
					trst_n_nxt = 1'b1;
					state_nxt = D_IDLE;
				end
			end
			default: begin
				state_nxt = D_IDLE;
				oe_nxt = 1'b0;
				o_nxt = 1'b0;
			end
		endcase
	end

	// state registers
	always_ff @(posedge clk) begin
		if (reset) begin
			state_r <= D_IDLE;
			cnt_r <= '0;
			oe_r <= 1'b0;
			o_r <= 1'b0;
			marker_r <= 1'b0;
			tdi_r <= 1'b0;
			tms_r <= 1'b0;
			tck_r <= 1'b0;
			ttdi_r <= 1'b0;
			ttms_r <= 1'b0;
			trst_n_r <= 1'b1;
			tdo_bit_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			oe_r <= oe_nxt;
			o_r <= o_nxt;
			marker_r <= marker_nxt;
			tdi_r <= tdi_nxt;
			tms_r <= tms_nxt;
			tck_r <= tck_nxt;
			ttdi_r <= ttdi_nxt;
			ttms_r <= ttms_nxt;
			trst_n_r <= trst_n_nxt;
			tdo_bit_r <= tdo_bit_nxt;
		end
	end

	// outputs
	assign link.dev_oe = oe_r;
	assign link.dev_o = o_r;
	assign tap_tck = tck_r;
	assign tap_tdi = ttdi_r;
	assign tap_tms = ttms_r;
	assign tap_trst_n = trst_n_r;
	assign busy = state_r != D_IDLE;
endmodule // swdb_device

// >>> hdl/swdb_adapter.sv
`include "swdb_params.svh"

module swdb_adapter import swdb_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// one-wire link
	swdb_if.adapter link,
	// debugger request
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_reset,
	input wire logic req_tdi,
	input wire logic req_tms,
	// debugger response
	output logic rsp_valid,
	output logic rsp_tdo
);
	swdb_ada_state_e state_r, state_nxt;
	swdb_cnt_t cnt_r, cnt_nxt;
	logic oe_r, oe_nxt;
	logic o_r, o_nxt;
	logic seen_hi_r, seen_hi_nxt;
	logic rst_op_r, rst_op_nxt;
	logic tdi_r, tdi_nxt;
	logic tms_r, tms_nxt;
	logic rsp_valid_r, rsp_valid_nxt;
	logic rsp_tdo_r, rsp_tdo_nxt;
	logic line_s;

	swdb_sync u_line (
		.clk(clk),
		.reset(reset),
		.d(link.line),
		.q(line_s)
	);

	// slot boundaries count from the first cycle of slot 0, at_tdo from A_TDO entry, end_gap from quiet in A_DONE
	wire bit_end = cnt_r == swdb_cnt_t'(`SWDB_BIT_CYC - 1);
	wire end_s1 = cnt_r == swdb_cnt_t'(2 * `SWDB_BIT_CYC - 1);
	wire end_s2 = cnt_r == swdb_cnt_t'(3 * `SWDB_BIT_CYC - 1);
	wire end_low = cnt_r == swdb_cnt_t'(3 * `SWDB_BIT_CYC + `SWDB_HALF_CYC - 1);
	wire end_send = cnt_r == swdb_cnt_t'(4 * `SWDB_BIT_CYC - 1);
	wire at_tdo = cnt_r == swdb_cnt_t'(`SWDB_BIT_CYC + `SWDB_HALF_CYC - 1);
	wire end_gap = cnt_r == swdb_cnt_t'(`SWDB_GAP_CYC - 1);
	wire swdb_cnt_t cnt_inc = swdb_cnt_t'(cnt_r + swdb_cnt_t'(1)); // full counter width

	// transaction sequencer
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_inc;
		oe_nxt = oe_r;
		o_nxt = o_r;
		seen_hi_nxt = seen_hi_r;
		rst_op_nxt = rst_op_r;
		tdi_nxt = tdi_r;
		tms_nxt = tms_r;
		rsp_valid_nxt = 1'b0;
		rsp_tdo_nxt = rsp_tdo_r;
		case (state_r)
			A_IDLE: begin
				cnt_nxt = '0;
				seen_hi_nxt = 1'b0;
				if (req_valid) begin
					rst_op_nxt = req_reset;
					tdi_nxt = req_tdi;
					tms_nxt = req_tms;
					oe_nxt = 1'b1;
					o_nxt = 1'b1;
					state_nxt = A_START;
				end
			end
			A_START: begin
				// high start pulse until the device answers with low
				cnt_nxt = '0;
				if (line_s) begin
					seen_hi_nxt = 1'b1;
				end
				if (seen_hi_r && !line_s) begin
					oe_nxt = 1'b0;
					state_nxt = A_MARK;
				end
			end
			A_MARK: begin
				if (bit_end) begin
					// first slot: high asks for a clock, low for a reset
					oe_nxt = 1'b1;
					o_nxt = ~rst_op_r;
					cnt_nxt = '0;
					state_nxt = A_SEND;
				end
			end
			A_SEND: begin
				if (bit_end) begin
					o_nxt = tdi_r;
				end
				if (end_s1) begin
					o_nxt = tms_r;
				end
				if (end_s2) begin
					o_nxt = 1'b0;
				end
				if (end_low) begin
					oe_nxt = 1'b0;
				end
				if (end_send) begin
					cnt_nxt = '0;
					state_nxt = rst_op_r ? A_DONE : A_WAIT;
				end
			end
			A_WAIT: begin
				cnt_nxt = '0;
				if (line_s) begin
					state_nxt = A_TDO;
				end
			end
			A_TDO: begin
				// middle of the period after the high pulse
				if (at_tdo) begin
					rsp_tdo_nxt = line_s;
					cnt_nxt = '0;
					state_nxt = A_DONE;
				end
			end
			A_DONE: begin
				// wire left to the pulldown before the next start
				oe_nxt = 1'b0;
				if (line_s) begin
					cnt_nxt = '0;
				end else if (end_gap) begin
					rsp_valid_nxt = 1'b1;
					state_nxt = A_IDLE;
				end
			end
			default: begin
				state_nxt = A_IDLE;
				oe_nxt = 1'b0;
				o_nxt = 1'b0;
			end
		endcase
	end

	// state registers
	always_ff @(posedge clk) begin
		if (reset) begin
			state_r <= A_IDLE;
			cnt_r <= '0;
			oe_r <= 1'b0;
			o_r <= 1'b0;
			seen_hi_r <= 1'b0;
			rst_op_r <= 1'b0;
			tdi_r <= 1'b0;
			tms_r <= 1'b0;
			rsp_valid_r <= 1'b0;
			rsp_tdo_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			oe_r <= oe_nxt;
			o_r <= o_nxt;
			seen_hi_r <= seen_hi_nxt;
			rst_op_r <= rst_op_nxt;
			tdi_r <= tdi_nxt;
			tms_r <= tms_nxt;
			rsp_valid_r <= rsp_valid_nxt;
			rsp_tdo_r <= rsp_tdo_nxt;
		end
	end

	// outputs
	assign link.ada_oe = oe_r;
	assign link.ada_o = o_r;
	assign req_ready = state_r == A_IDLE;
	assign rsp_valid = rsp_valid_r;
	assign rsp_tdo = rsp_tdo_r;
endmodule // swdb_adapter

// >>> dv/swdb_checker.sv
module swdb_checker (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// wire signals
	input wire logic dev_o,
	input wire logic dev_oe,
	input wire logic ada_o,
	input wire logic ada_oe,
	input wire logic line
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	// device low mark, then its reply: high pulse, tdo bit, release
	sequence s_mark;
		(dev_oe && !dev_o)[*5] ##1 !dev_oe;
	endsequence
	sequence s_reply;
		(dev_oe && dev_o)[*5] ##1 dev_oe[*5] ##1 !dev_oe;
	endsequence

	a_mark_low_len: assert property ($rose(dev_oe) && !dev_o |-> s_mark)
		else $error("mark length wrong");
	a_mark_after_start: assert property ($rose(dev_oe) && !dev_o |-> $past(line))
		else $error("mark without start");
	a_reply_len: assert property ($rose(dev_oe) && dev_o |-> s_reply)
		else $error("reply framing wrong");
	a_reply_quiet: assert property (dev_oe && dev_o |-> !ada_oe)
		else $error("adapter drives during reply");
	a_start_release: assert property (ada_oe && ada_o && !line |-> ##[1:5] !ada_oe)
		else $error("start not released");
	a_slot_gap: assert property ($fell(ada_oe) && $past(ada_o) |-> !ada_oe[*5] ##1 ada_oe)
		else $error("marker slot misplaced");
	a_send_tail_low: assert property ($fell(ada_oe) && !$past(ada_o) |-> !$past(ada_o, 2))
		else $error("send tail not low");
	a_release_idle: assert property ($fell(dev_oe) |-> !ada_oe && !line)
		else $error("wire not idle");
endmodule // swdb_checker

// >>> dv/swdb_tb.sv
module swdb_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic rst; logic tdi; logic tms; logic tdo;} swdb_note_s;
	logic clk, reset, req_valid, req_ready, req_reset, req_tdi, req_tms, rsp_valid, rsp_tdo;
	logic tck, tdi, tms, trst_n, rtck, tdo, tck2, trst2_n, g_oe, exp_tdo, saw_trst, g, bad;
	logic dev_busy;
	int num_errors, total_checks, dly, k, i, j;
	swdb_note_s notes[$];
	swdb_note_s n;
	swdb_if lk();
	swdb_if lk2();

	// glitch driver on the second wire
	assign lk2.ada_o = 1'b1;
	assign lk2.ada_oe = g_oe;

	swdb_device u_swdb_device (.clk(clk), .reset(reset), .link(lk.device), .tap_tck(tck),
		.tap_tdi(tdi), .tap_tms(tms), .tap_trst_n(trst_n), .tap_rtck(rtck), .tap_tdo(tdo),
		.busy(dev_busy));
	swdb_adapter u_swdb_adapter (.clk(clk), .reset(reset), .link(lk.adapter),
		.req_valid(req_valid), .req_ready(req_ready), .req_reset(req_reset),
		.req_tdi(req_tdi), .req_tms(req_tms), .rsp_valid(rsp_valid), .rsp_tdo(rsp_tdo));
	swdb_device u_swdb_device2 (.clk(clk), .reset(reset), .link(lk2.device), .tap_tck(tck2),
		.tap_tdi(), .tap_tms(), .tap_trst_n(trst2_n), .tap_rtck(1'b0), .tap_tdo(1'b0),
		.busy());
	swdb_checker u_swdb_checker (.clk(clk), .reset(reset), .dev_o(lk.dev_o),
		.dev_oe(lk.dev_oe), .ada_o(lk.ada_o), .ada_oe(lk.ada_oe), .line(lk.line));

	task fail(input string m);
		num_errors++;
		$display("mismatch at %0t: %s", $time, m);
	endtask

	task test_done;
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// one request, noted in the queue, then wait for its response
	task op(input logic r, input logic ti, input logic tm);
		notes.push_back('{r, ti, tm, 1'($urandom())});
		req_reset = r;
		req_tdi = ti;
		req_tms = tm;
		req_valid = 1'b1;
		@(posedge clk);
		#1 req_valid = 1'b0;
		k = 0;
		do begin
			@(posedge clk);
			#1 k++;
		end while (rsp_valid !== 1'b1 && k < 3000);
		if (k >= 3000) fail("no response");
		@(posedge clk);
		#1 total_checks++;
		if (req_ready !== 1'b1 || dev_busy !== 1'b0) fail("ends not idle");
	endtask

	// tap model: check bits at tck rise, answer after a random wait
	always @(posedge tck) begin
		#1 total_checks += 3;
		if (notes.size() == 0 || notes[0].rst !== 1'b0 || tdi !== notes[0].tdi ||
			tms !== notes[0].tms) fail("tap bits");
		if (dev_busy !== 1'b1) fail("device not busy at tck");
		dly = $urandom_range(0, 30);
		repeat (dly) @(posedge clk);
		#1 tdo = notes[0].tdo;
		@(posedge clk);
		#1 if (tck !== 1'b1) fail("tck dropped early");
		rtck = 1'b1;
		for (j = 0; j < 20 && tck === 1'b1; j++) @(posedge clk);
		#1 rtck = 1'b0;
	end

	always @(negedge trst_n) saw_trst = 1'b1;

	// response monitor takes the oldest note
	always begin
		@(posedge clk);
		#2;
		if (rsp_valid === 1'b1) begin
			total_checks += 2;
			if (notes.size() == 0) fail("unexpected response");
			else begin
				n = notes.pop_front();
				if (!n.rst) exp_tdo = n.tdo;
				if (rsp_tdo !== exp_tdo) fail("tdo value");
				if (saw_trst !== n.rst) fail("tap reset");
			end
			saw_trst = 1'b0;
		end
	end

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	initial begin
		repeat (40000) @(posedge clk);
		fail("timeout");
		test_done;
	end

	initial begin
		void'($urandom(32'h9363));
		{reset, req_valid, req_reset, req_tdi, req_tms} = 5'h10;
		{rtck, tdo, g_oe, saw_trst, exp_tdo} = 5'h00;
		num_errors = 0;
		total_checks = 0;
		repeat (2) @(posedge clk);
		#1 reset = 1'b0;
		for (i = 0; i < 4; i++) op(1'b0, i[0], i[1]);
		$display("test clock ops done");
		op(1'b1, 1'b0, 1'b0);
		op(1'b1, 1'b1, 1'b1);
		op(1'b0, 1'b1, 1'b0);
		$display("test reset ops done");
		for (i = 0; i < 20; i++) op($urandom_range(0, 3) == 0, 1'($urandom()), 1'($urandom()));
		$display("test random ops done");
		g_oe = 1'b1;
		repeat (4) @(posedge clk);
		#1 g_oe = 1'b0;
		g = 1'b0;
		bad = 1'b0;
		for (k = 0; k < 200; k++) begin
			@(posedge clk);
			#1 if (trst2_n === 1'b0) g = 1'b1;
			if (tck2 !== 1'b0) bad = 1'b1;
		end
		total_checks += 2;
		if (g !== 1'b1) fail("glitch gave no tap reset");
		if (bad !== 1'b0) fail("glitch gave a clock");
		$display("test glitch done");
		test_done;
	end
endmodule // swdb_tb
